// *** fade_and_dot_mask_ram.sv ***
// per-dot fade parameter memory and on/off mask memory with command sequencer
// What this block does
// - a 36-byte fade memory holds a mode bit and a three-bit time code for every dot.
// - fade write is command 82h, an address byte, then data bytes with two dots each.
// - mode bit 0 gives fade mode (the default) and 1 gives blink mode.
// - the time code selects off, 256, 512, 1024, 1536, 2048, 2560 or 3072 frames.
// - in binary display mode the fade parameters are not applied.
// - one frame lasts (256+16)*9 periods of the 2.4 MHz oscillator, about 1.02 ms.
// - each row uses four fade addresses, lower nibble is the lower-numbered dot.
// - the fade address steps after each byte and wraps to 00h past 83h.
// - a 9-byte mask memory holds one bit per dot, one byte per row.
// - a mask bit of 1 enables the dot and 0 disables it.
// - mask addresses 00h to 08h are rows 1 to 9, bits D0 to D7 are columns 1 to 8.
// - mask bytes are written from the address byte's address, the address steps and wraps after 08h.
// - in binary display mode the mask is not applied.
// - fade read is command 83h and an address, answered by a zero byte then data.
// - mask write is command 84h, an address with upper three bits zero, then data.
`timescale 1ns/1ns
`include "fade_mask_consts.svh"

module fade_and_dot_mask_ram
	import fade_mask_pkg::*;
#(
	parameter int FRAME_CLKS = int'(`FRAME_CLKS)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// received bytes from the serial bus front end
	input wire logic rx_valid,
	input wire logic rx_start,
	input wire logic [7:0] rx_byte,
	// read-back bytes toward the serial bus front end
	input wire logic tx_req,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	// display mode: 1 gray, 0 binary
	input wire logic gray_mode,
	// period lookup for one dot
	input wire logic [6:0] query_dot,
	output logic [11:0] query_period_frames,
	// frame timing
	output logic frame_tick,
	// per-dot results toward the scan engine
	output logic [`DOTS-1:0] dot_enable,
	output logic [`DOTS-1:0] dot_blink,
	output logic [3*`DOTS-1:0] dot_time_code
);

	// storage
	logic [7:0] fade_mem [`FADE_BYTES];
	logic [7:0] mask_mem [`MASK_BYTES];

	// sequencer state
	seq_state_t state;
	op_t op;
	logic [7:0] addr;
	logic dummy_sent;
	logic [16:0] frame_cnt;

	// fade address maps to a real byte: row 0..8, offsets 0..3
	function automatic logic fade_addr_ok(input logic [7:0] a);
		fade_addr_ok = (a[7:4] <= `FADE_LAST_ROW) && (a[3:2] == 2'h0);
	endfunction

	// fade address to memory index, four bytes per row
	function automatic logic [5:0] fade_index(input logic [7:0] a);
		fade_index = 6'({a[7:4], 2'h0}) + 6'(a[1:0]);
	endfunction

	// next fade address: skip row gaps, wrap to 00h past the last byte
	function automatic logic [7:0] next_fade_addr(input logic [7:0] a);
		if (a == `FADE_MAX_ADDR) begin
			next_fade_addr = 8'h00;
		end else if (fade_addr_ok(a) && a[1:0] == `FADE_LAST_COL) begin
			next_fade_addr = {a[7:4] + 4'h1, 4'h0};
		end else begin
			next_fade_addr = a + 8'h01;
		end
	endfunction

	// next mask address, wrap to 00h after 08h
	function automatic logic [7:0] next_mask_addr(input logic [7:0] a);
		if (a >= `MASK_MAX_ADDR) begin
			next_mask_addr = 8'h00;
		end else begin
			next_mask_addr = a + 8'h01;
		end
	endfunction

	// time code to fade period in frames
	function automatic logic [11:0] period_frames(input logic [2:0] code);
		case (code)
			3'h0: period_frames = `PERIOD_OFF;
			3'h1: period_frames = `PERIOD_UNIT;
			3'h2: period_frames = `PERIOD_UNIT * 12'h2;
			3'h3: period_frames = `PERIOD_UNIT * 12'h4;
			3'h4: period_frames = `PERIOD_UNIT * 12'h6;
			3'h5: period_frames = `PERIOD_UNIT * 12'h8;
			3'h6: period_frames = `PERIOD_UNIT * 12'ha;
			default: period_frames = `PERIOD_UNIT * 12'hc;
		endcase
	endfunction

	// mode bit of one dot out of its two-dot byte, odd selects the high nibble
	function automatic logic dot_mode(input logic [7:0] b, input logic odd);
		dot_mode = odd ? b[`ODD_MODE_BIT] : b[`EVEN_MODE_BIT];
	endfunction

	// time code of one dot out of its two-dot byte, odd selects the high nibble
	function automatic logic [2:0] dot_code(input logic [7:0] b, input logic odd);
		dot_code = odd ? b[`ODD_TIME_HI:`ODD_TIME_LO] : b[`EVEN_TIME_HI:`EVEN_TIME_LO];
	endfunction

	// command sequencer: command byte, address byte, then data bytes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			op <= OP_NONE;
		end else if (rx_valid && rx_start) begin
			// a marked byte always ends the old sequence, only a known command opens a new one
			state <= ST_IDLE;
			op <= OP_NONE;
			unique case (rx_byte)
				`CMD_WR_FADE: begin
					state <= ST_ADDR;
					op <= OP_WFADE;
				end
				`CMD_RD_FADE: begin
					state <= ST_ADDR;
					op <= OP_RFADE;
				end
				`CMD_WR_MASK: begin
					state <= ST_ADDR;
					op <= OP_WMASK;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end else if (rx_valid) begin
			unique case (state)
				ST_ADDR: begin
					unique case (op)
						OP_WFADE: state <= ST_WFADE;
						OP_RFADE: state <= ST_RFADE;
						// upper address bits must be zero
						OP_WMASK: state <= (rx_byte[7:5] == 3'h0) ? ST_WMASK : ST_IDLE;
						default: state <= ST_IDLE;
					endcase
				end
				ST_RFADE: state <= ST_RFADE;
				ST_WFADE: state <= ST_WFADE;
				ST_WMASK: state <= ST_WMASK;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// address pointer: load from address byte, step after each data byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr <= 8'h00;
		end else if (rx_valid && !rx_start) begin
			if (state == ST_ADDR) begin
				addr <= rx_byte;
			end else if (state == ST_WFADE) begin
				addr <= next_fade_addr(addr);
			end else if (state == ST_WMASK) begin
				addr <= next_mask_addr(addr);
			end
		end else if (state == ST_RFADE && tx_req && dummy_sent && !rx_valid) begin
			addr <= next_fade_addr(addr);
		end
	end

	// fade memory: cleared at reset, written two dots per byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `FADE_BYTES; i++) begin
				fade_mem[i] <= `FADE_RESET;
			end
		end else if (rx_valid && !rx_start && state == ST_WFADE && fade_addr_ok(addr)) begin
			fade_mem[fade_index(addr)] <= rx_byte;
		end
	end

	// mask memory: cleared at reset, one byte per row
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `MASK_BYTES; i++) begin
				mask_mem[i] <= `MASK_RESET;
			end
		end else if (rx_valid && !rx_start && state == ST_WMASK && addr <= `MASK_MAX_ADDR) begin
			mask_mem[addr[3:0]] <= rx_byte;
		end
	end

	// read path: zero dummy first, then stored bytes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_byte <= `DUMMY_BYTE;
			tx_valid <= 1'b0;
			dummy_sent <= 1'b0;
		end else begin
			tx_valid <= 1'b0;
			if (state != ST_RFADE) begin
				dummy_sent <= 1'b0;
			end
			if (state == ST_RFADE && tx_req && !rx_valid) begin
				tx_valid <= 1'b1;
				if (!dummy_sent) begin
					tx_byte <= `DUMMY_BYTE;
					dummy_sent <= 1'b1;
				end else if (fade_addr_ok(addr)) begin
					tx_byte <= fade_mem[fade_index(addr)];
				end else begin
					tx_byte <= 8'h00;
				end
			end
		end
	end

	// frame counter on the system clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_cnt <= 17'h00000;
			frame_tick <= 1'b0;
		end else if (frame_cnt >= 17'(FRAME_CLKS - 1)) begin
			frame_cnt <= 17'h00000;
			frame_tick <= 1'b1;
		end else begin
			frame_cnt <= frame_cnt + 17'h00001;
			frame_tick <= 1'b0;
		end
	end

	// period lookup for the queried dot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			query_period_frames <= `PERIOD_OFF;
		end else if (!gray_mode || query_dot >= 7'(`DOTS)) begin
			// no fade timing in binary mode
			query_period_frames <= `PERIOD_OFF;
		end else begin
			query_period_frames <= period_frames(dot_code(
				fade_mem[6'({query_dot[6:3], 2'h0}) + 6'(query_dot[2:1])], query_dot[0]));
		end
	end

	// per-dot enable toward the scan engine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dot_enable <= '0;
		end else begin
			for (int r = 0; r < `ROWS; r++) begin
				for (int c = 0; c < `COLS; c++) begin
					if (gray_mode) begin
						dot_enable[r*`COLS+c] <= mask_mem[r][c];
					end else begin
						dot_enable[r*`COLS+c] <= 1'b1;
					end
				end
			end
		end
	end

	// per-dot mode and time code toward the scan engine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dot_blink <= '0;
			dot_time_code <= '0;
		end else begin
			for (int r = 0; r < `ROWS; r++) begin
				for (int c = 0; c < `COLS; c++) begin
					if (gray_mode) begin
						dot_blink[r*`COLS+c] <= dot_mode(fade_mem[r*4+c/2], c[0]);
						// time code of the dot's nibble
						dot_time_code[3*(r*`COLS+c) +: 3] <= dot_code(fade_mem[r*4+c/2], c[0]);
					end else begin
						dot_blink[r*`COLS+c] <= 1'b0;
						dot_time_code[3*(r*`COLS+c) +: 3] <= 3'h0;
					end
				end
			end
		end
	end

endmodule // fade_and_dot_mask_ram

// *** fade_mask_asserts.sv ***
// concurrent checks on the fade and mask memory ports
`timescale 1ns/1ns
`include "fade_mask_consts.svh"
module fade_mask_asserts #(
	parameter int FRAME_CLKS = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// requests
	input wire logic rx_valid,
	input wire logic tx_req,
	input wire logic gray_mode,
	// results
	input wire logic tx_valid,
	input wire logic [11:0] query_period_frames,
	input wire logic frame_tick,
	input wire logic [`DOTS-1:0] dot_enable,
	input wire logic [`DOTS-1:0] dot_blink,
	input wire logic [3*`DOTS-1:0] dot_time_code
);
	// cycles since the last frame tick or reset, keeps long frames out of the properties
	int gap;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gap <= 0;
		end else if (frame_tick) begin
			gap <= 1;
		end else begin
			gap <= gap + 1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_tick_period: assert property (frame_tick |-> gap == FRAME_CLKS) else $error("tick gap");
	a_tick_late: assert property (gap <= FRAME_CLKS) else $error("tick late");
	a_tick_single: assert property (frame_tick |=> !frame_tick) else $error("tick too long");
	a_bin_enable: assert property ($past(rst_n) && !$past(gray_mode) |-> &dot_enable)
		else $error("binary masked");
	a_bin_fade: assert property ($past(rst_n) && !$past(gray_mode) |-> !(|{dot_blink, dot_time_code}))
		else $error("binary fade");
	a_bin_query: assert property ($past(rst_n) && !$past(gray_mode) |-> query_period_frames == 12'h000)
		else $error("binary period");
	a_reset_clear: assert property ($rose(rst_n) |-> !(|{dot_enable, dot_blink, dot_time_code}))
		else $error("not cleared");
	a_period_set: assert property (query_period_frames[7:0] == 8'h00 &&
		query_period_frames[11:8] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc}) else $error("bad period");
	a_tx_cause: assert property (tx_valid |-> $past(tx_req) && !$past(rx_valid)) else $error("stray answer");
	a_mem_stable: assert property ($past(gray_mode) && $past(gray_mode, 2) && $past(rst_n) && $past(rst_n, 2) &&
		!$past(rx_valid, 2) |-> $stable(dot_enable) && $stable(dot_blink)) else $error("dots moved");
endmodule // fade_mask_asserts

bind fade_and_dot_mask_ram fade_mask_asserts #(.FRAME_CLKS(FRAME_CLKS)) chk (.clk(clk), .rst_n(rst_n),
	.rx_valid(rx_valid), .tx_req(tx_req), .gray_mode(gray_mode), .tx_valid(tx_valid),
	.query_period_frames(query_period_frames), .frame_tick(frame_tick), .dot_enable(dot_enable),
	.dot_blink(dot_blink), .dot_time_code(dot_time_code));

// *** fade_mask_consts.svh ***
// offsets, field positions, reset values and timing counts of the fade and mask memories
`ifndef FADE_MASK_CONSTS_SVH
`define FADE_MASK_CONSTS_SVH

// command bytes
`define CMD_WR_FADE 8'h82
`define CMD_RD_FADE 8'h83
`define CMD_WR_MASK 8'h84
`define DUMMY_BYTE 8'h00

// memory geometry
`define ROWS 9
`define COLS 8
`define DOTS 72
`define FADE_BYTES 36
`define MASK_BYTES 9
`define FADE_MAX_ADDR 8'h83
`define MASK_MAX_ADDR 8'h08
`define FADE_LAST_ROW 4'h8
`define FADE_LAST_COL 2'h3

// data byte layout of a fade byte: odd dot in high nibble, even dot in low
`define ODD_MODE_BIT 7
`define ODD_TIME_HI 6
`define ODD_TIME_LO 4
`define EVEN_MODE_BIT 3
`define EVEN_TIME_HI 2
`define EVEN_TIME_LO 0

// reset values: fade mode, time off, mask off
`define FADE_RESET 8'h00
`define MASK_RESET 8'h00

// fade period per time code, in frames
`define PERIOD_UNIT 12'h100
`define PERIOD_OFF 12'h000

// frame timing
`define FRAME_SYS_CYCLES ((256 + 16) * 9)
`define SYS_FREQ_HZ 2400000
`define CLK_FREQ_HZ 125000000
`define FRAME_CLKS ((64'd1 * `FRAME_SYS_CYCLES * `CLK_FREQ_HZ) / `SYS_FREQ_HZ)

`endif

// *** fade_mask_host.sv ***
// host model that sends command bytes and pulls read bytes
`timescale 1ns/1ns
module fade_mask_host (
	// clock
	input wire logic clk,
	// toward the block
	output logic rx_valid,
	output logic rx_start,
	output logic [7:0] rx_byte,
	output logic tx_req,
	// from the block
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid
);
	// idle bus at time zero
	initial begin
		rx_valid = 1'h0;
		rx_start = 1'h0;
		rx_byte = 8'h00;
		tx_req = 1'h0;
	end
	task put(input logic s, input logic [7:0] b);
		@(negedge clk);
		rx_valid = 1'h1;
		rx_start = s;
		rx_byte = b;
	endtask
	// released lane shows the inverse
	task idle();
		@(negedge clk);
		rx_valid = 1'h0;
		rx_start = 1'h0;
		rx_byte = ~rx_byte;
	endtask
	task pull(output logic [7:0] d);
		idle();
		tx_req = 1'h1;
		@(negedge clk);
		tx_req = 1'h0;
		d = tx_valid ? tx_byte : 8'hxx;
	endtask
endmodule // fade_mask_host

// *** fade_mask_pkg.sv ***
// types shared by the fade and mask memory block
package fade_mask_pkg;

	// command sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_WFADE = 5'b00100,
		ST_RFADE = 5'b01000,
		ST_WMASK = 5'b10000
	} seq_state_t;

	// which command opened the sequence
	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_WFADE = 2'h1,
		OP_RFADE = 2'h2,
		OP_WMASK = 2'h3
	} op_t;

endpackage

// *** testbench.sv ***
// self-checking bench for the fade and mask memory block
`timescale 1ns/1ns
`include "fade_mask_consts.svh"
module testbench;
	typedef struct {logic [2:0] code; logic [11:0] frames;} row_t;
	logic clk, rst_n, gray_mode, rx_valid, rx_start, tx_req, tx_valid, frame_tick;
	logic [7:0] rx_byte, tx_byte, d;
	logic [6:0] query_dot;
	logic [11:0] query_period_frames;
	logic [`DOTS-1:0] dot_enable, dot_blink, exp_en;
	logic [3*`DOTS-1:0] dot_time_code;
	logic [7:0] exp_rd [3] = '{8'h00, 8'ha5, 8'h5a};
	int fails, compares;
	row_t rows [8] = '{'{3'h0, 12'h000}, '{3'h1, 12'h100}, '{3'h2, 12'h200}, '{3'h3, 12'h400},
		'{3'h4, 12'h600}, '{3'h5, 12'h800}, '{3'h6, 12'ha00}, '{3'h7, 12'hc00}};
	fade_and_dot_mask_ram #(.FRAME_CLKS(20)) uut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
		.rx_start(rx_start), .rx_byte(rx_byte), .tx_req(tx_req), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.gray_mode(gray_mode), .query_dot(query_dot), .query_period_frames(query_period_frames),
		.frame_tick(frame_tick), .dot_enable(dot_enable), .dot_blink(dot_blink), .dot_time_code(dot_time_code));
	fade_mask_host host (.clk(clk), .rx_valid(rx_valid), .rx_start(rx_start), .rx_byte(rx_byte),
		.tx_req(tx_req), .tx_byte(tx_byte), .tx_valid(tx_valid));
	// clock
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// compare any result, zero extended
	task chk(input logic [215:0] got, input logic [215:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// command, address, one data byte then settle
	task wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
		host.put(1'h1, c);
		host.put(1'h0, a);
		host.put(1'h0, b);
		host.idle();
		@(negedge clk);
	endtask
	// verdict
	task wrap_up();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		wrap_up();
	end
	// main sequence
	initial begin
		fails = 0;
		compares = 0;
		rst_n = 1'h0;
		gray_mode = 1'h1;
		query_dot = 7'h01;
		repeat (12) @(negedge clk);
		rst_n = 1'h1;
		@(negedge clk);
		chk(dot_time_code, '0); // codes cleared
		chk({dot_enable, dot_blink}, '0); // mask and mode cleared
		foreach (rows[i]) begin
			wr(8'h82, 8'h00, {1'h1, rows[i].code, 1'h0, rows[i].code});
			chk(dot_time_code[5:0], {rows[i].code, rows[i].code}); // time codes of dots 0 and 1, same code in both nibbles
			chk(dot_blink[1:0], 2'h2); // mode bits
			chk(query_period_frames, rows[i].frames); // period table
		end
		host.put(1'h1, 8'h82);
		host.put(1'h0, 8'h83);
		host.put(1'h0, 8'ha5);
		host.put(1'h0, 8'h5a);
		host.idle();
		@(negedge clk);
		chk({dot_time_code[215:210], dot_blink[71:70]}, {3'h2, 3'h5, 2'h2}); // last address
		chk({dot_time_code[5:0], dot_blink[1:0]}, {3'h5, 3'h2, 2'h1}); // wrap to zero
		query_dot = 7'h47;
		@(negedge clk);
		chk(query_period_frames, 12'h200); // dot lookup
		host.put(1'h1, 8'h83);
		host.put(1'h0, 8'h83);
		foreach (exp_rd[i]) begin
			host.pull(d);
			chk(d, exp_rd[i]); // dummy then data
		end
		host.put(1'h1, 8'h84);
		host.put(1'h0, 8'h00);
		for (int r = 0; r < 10; r++) begin
			host.put(1'h0, 8'h80 | 8'(r));
			exp_en[8 * (r % 9) +: 8] = 8'h80 | 8'(r);
		end
		host.idle();
		@(negedge clk);
		chk(dot_enable, exp_en); // row wrap
		wr(8'h84, 8'h20, 8'hff);
		chk(dot_enable, exp_en); // bad address
		gray_mode = 1'h0;
		@(negedge clk);
		chk({dot_enable, dot_blink}, {{72{1'h1}}, 72'h0}); // binary mode
		chk(query_period_frames, 12'h000); // no period
		gray_mode = 1'h1;
		rst_n = 1'h0;
		repeat (2) @(negedge clk);
		rst_n = 1'h1;
		repeat (2) @(negedge clk);
		chk({dot_enable, dot_blink}, '0); // memories cleared mid-run
		chk(dot_time_code, '0); // codes cleared mid-run
		repeat (17) @(negedge clk);
		chk(frame_tick, 1'h0); // no tick before a frame
		@(negedge clk);
		chk(frame_tick, 1'h1); // tick after one frame
		wrap_up();
	end
endmodule // testbench
